// file: hw/qdac_rx.sv
/*
 * quad dac i2c command receiver: write-only i2c slave, staging and active
 * code registers, power-down and power-up delay tracking, apb status view.
 * assumes scl/sda arrive asynchronously and scl is far slower than pclk.
 */
// Decided for this implementation: the APB slave port and the placing of the registers.
//
// Contract
// - ack address matching pins or global
// - ack each of three data bytes
// - execute only after 24 bits received
// - extra data bytes are not acknowledged
// - first byte holds command and channel
// - bytes two, three are msb-first code
// - 0000 writes staging register only
// - 0001 updates and powers channel up
// - 0010 writes then updates all channels
// - 0011 writes and updates same channel
// - 0100 powers channels down, data ignored
// - channel codes 0-3 plus 1111 all
// - write moves data word into staging
// - update copies staging into active
// - update clears channel power-down
// - powered-down output is high impedance
// - power-down keeps register contents
// - independent power-down, only update wakes
// - wake delay 5 us normally
// - all down: bias off, 12/30 us wake
// - read address never acknowledged
// - global address 1110011 also accepted
`timescale 1ns/100ps
`default_nettype none
`include "qdac_defs.svh"

module qdac_rx #(
	parameter logic [15:0] RESET_CODE = `QDAC_CODE_ZERO
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// i2c pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// address select, already resolved to a 7-bit address
	input  wire logic [6:0]  slave_addr,
	// dac side
	output logic [63:0]      dac_code,
	output logic [3:0]       dac_powered_down,
	output logic [3:0]       dac_settling,
	output logic             bias_off
);

////////////////////////////////////////////////////////////////////////////////

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_d_reg;
	logic       sda_d_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	wire scl      = scl_sync_reg[1];
	wire sda      = sda_sync_reg[1];
	wire scl_rise = scl & ~scl_d_reg;
	wire scl_fall = ~scl & scl_d_reg;
	wire start_c  = scl & scl_d_reg & sda_d_reg & ~sda;
	wire stop_c   = scl & scl_d_reg & ~sda_d_reg & sda;

////////////////////////////////////////////////////////////////////////////////

	qdac_pkg::qdac_state_t state_reg;
	qdac_pkg::qdac_state_t state_next;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [1:0]  byte_cnt_reg;
	logic [23:0] word_reg;
	logic        ack_reg;
	logic        exec_reg;

	// shift in msb first, so byte 1 high nibble is the command
	wire [7:0] shift_in = {shift_reg[6:0], sda};
	wire       addr_hit = (shift_in[7:1] == slave_addr) ||
	                      (shift_in[7:1] == `QDAC_GLOBAL_ADDR);
	wire       addr_ok  = addr_hit && !shift_in[0];
	wire       byte_done = scl_rise && (bit_cnt_reg == 4'd7);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			qdac_pkg::QDAC_IDLE: state_next = state_reg;
			qdac_pkg::QDAC_ADDR:
				if (byte_done)
					state_next = addr_ok ? qdac_pkg::QDAC_ACK :
					                       qdac_pkg::QDAC_SKIP;
			qdac_pkg::QDAC_DATA:
				if (byte_done)
					state_next = (byte_cnt_reg == 2'd3) ?
					    qdac_pkg::QDAC_SKIP : qdac_pkg::QDAC_ACK;
			qdac_pkg::QDAC_ACK:
				if (scl_fall && bit_cnt_reg == 4'd9)
					state_next = qdac_pkg::QDAC_DATA;
			qdac_pkg::QDAC_SKIP: state_next = state_reg;
			default: state_next = qdac_pkg::QDAC_IDLE;
		endcase
		// a new start restarts address reception, a stop drops everything
		if (start_c)
			state_next = qdac_pkg::QDAC_ADDR;
		else if (stop_c)
			state_next = qdac_pkg::QDAC_IDLE;
	end

	// one condition per register keeps every flop block a few lines long
	wire in_shift  = (state_reg == qdac_pkg::QDAC_ADDR) ||
	                 (state_reg == qdac_pkg::QDAC_DATA);
	wire in_ack    = (state_reg == qdac_pkg::QDAC_ACK);
	wire bus_cond  = start_c || stop_c;
	wire ack_set   = in_ack && scl_fall && (bit_cnt_reg == 4'd8);
	wire ack_end   = in_ack && scl_fall && (bit_cnt_reg == 4'd9);
	wire take_byte = !bus_cond && byte_done &&
	                 (state_reg == qdac_pkg::QDAC_DATA) &&
	                 (byte_cnt_reg != 2'd3);

	wire [3:0]  bit_cnt_next  = (bus_cond || ack_end) ? 4'd0 :
	                            ((in_shift || in_ack) && scl_rise) ?
	                            bit_cnt_reg + 4'd1 : bit_cnt_reg;
	wire [7:0]  shift_next    = (!bus_cond && in_shift && scl_rise) ?
	                            shift_in : shift_reg;
	wire [1:0]  byte_cnt_next = bus_cond ? 2'd0 :
	                            take_byte ? byte_cnt_reg + 2'd1 :
	                            byte_cnt_reg;
	wire [23:0] word_next     = take_byte ? {word_reg[15:0], shift_in} :
	                            word_reg;
	// ack from the fall after bit 8 to the fall after bit 9
	wire        ack_next      = (bus_cond || ack_end) ? 1'b0 :
	                            ack_set ? 1'b1 :
	                            ack_reg;
	// a cut word never gets here: start or stop clears byte_cnt first
	wire        exec_next     = take_byte &&
	                            (byte_cnt_reg == 2'd2);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_reg <= qdac_pkg::QDAC_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bit_cnt_reg <= 4'd0;
		else
			bit_cnt_reg <= bit_cnt_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			shift_reg <= 8'h00;
		else
			shift_reg <= shift_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			byte_cnt_reg <= 2'd0;
		else
			byte_cnt_reg <= byte_cnt_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			word_reg <= 24'h00_0000;
		else
			word_reg <= word_next;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ack_reg <= 1'b0;
		else
			ack_reg <= ack_next;
	end

	// exec is a one-cycle strobe, so a command never runs twice
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			exec_reg <= 1'b0;
		else
			exec_reg <= exec_next;
	end

	// open drain: enable low while pulling sda low
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~ack_reg;

////////////////////////////////////////////////////////////////////////////////

	qdac_pkg::qdac_word_t cmd;
	assign cmd = word_reg;

	function automatic logic [3:0] chan_mask(input logic [3:0] sel);
		case (sel)
			4'h0:         chan_mask = 4'b0001;
			4'h1:         chan_mask = 4'b0010;
			4'h2:         chan_mask = 4'b0100;
			4'h3:         chan_mask = 4'b1000;
			`QDAC_CH_ALL: chan_mask = 4'b1111;
			default:      chan_mask = 4'b0000;
		endcase
	endfunction

	wire [3:0] sel_mask = chan_mask(cmd.channel_select_field);
	wire is_wr   = (cmd.command_field == `QDAC_CMD_WRITE) ||
	               (cmd.command_field == `QDAC_CMD_WRITE_UPALL) ||
	               (cmd.command_field == `QDAC_CMD_WRITE_UP);
	wire is_upd  = (cmd.command_field == `QDAC_CMD_UPDATE) ||
	               (cmd.command_field == `QDAC_CMD_WRITE_UP);
	wire is_all  = (cmd.command_field == `QDAC_CMD_WRITE_UPALL);
	wire is_pd   = (cmd.command_field == `QDAC_CMD_POWERDOWN);
	wire [3:0] wr_mask  = (exec_reg && is_wr) ? sel_mask : 4'b0000;
	wire [3:0] upd_mask = !exec_reg ? 4'b0000 :
	                      is_all ? 4'b1111 :
	                      is_upd ? sel_mask : 4'b0000;
	wire [3:0] pd_mask  = (exec_reg && is_pd) ? sel_mask : 4'b0000;

	logic [15:0] stage_reg  [4];
	logic [15:0] active_reg [4];
	logic [3:0]  pd_reg;
	logic [10:0] settle_reg [4];
	logic        pup_3v_reg;

	// every channel down means the bias block is off and wake is slower
	wire        all_down = (pd_reg == 4'b1111);
	wire [10:0] wake_cyc = !all_down ? 11'(`QDAC_PUP_SHORT_CYC) :
	                       pup_3v_reg ? 11'(`QDAC_PUP_3V_CYC) :
	                       11'(`QDAC_PUP_5V_CYC);

	logic [15:0] stage_next  [4];
	logic [15:0] active_next [4];
	logic [10:0] settle_next [4];
	logic [3:0]  pd_next;

	always_comb begin
		pd_next = pd_reg;
		for (int i = 0; i < 4; i++) begin
			stage_next[i]  = stage_reg[i];
			active_next[i] = active_reg[i];
			settle_next[i] = settle_reg[i];
			// write happens before update so 0010/0011 see new data
			if (wr_mask[i])
				stage_next[i] = cmd.data_word;
			if (upd_mask[i]) begin
				active_next[i] = wr_mask[i] ? cmd.data_word :
				                 stage_reg[i];
				pd_next[i]     = 1'b0;
				settle_next[i] = pd_reg[i] ? wake_cyc : 11'd0;
			end else begin
				if (pd_mask[i])
					pd_next[i] = 1'b1;
				if (settle_reg[i] != 11'd0)
					settle_next[i] = settle_reg[i] - 11'd1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++)
				stage_reg[i] <= RESET_CODE;
		end else begin
			for (int i = 0; i < 4; i++)
				stage_reg[i] <= stage_next[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++)
				active_reg[i] <= RESET_CODE;
		end else begin
			for (int i = 0; i < 4; i++)
				active_reg[i] <= active_next[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pd_reg <= 4'b0000;
		else
			pd_reg <= pd_next;
	end

	// settling only times the wake; the code itself is live at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++)
				settle_reg[i] <= 11'd0;
		end else begin
			for (int i = 0; i < 4; i++)
				settle_reg[i] <= settle_next[i];
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			dac_code[16*i +: 16] = active_reg[i];
			dac_settling[i]      = (settle_reg[i] != 11'd0);
		end
	end
	assign dac_powered_down = pd_reg;
	assign bias_off         = all_down;

////////////////////////////////////////////////////////////////////////////////

	// zero wait state slave; unmapped addresses answer with pslverr
	wire acc     = psel && penable;
	wire a_ctrl  = (paddr == `QDAC_APB_CTRL);
	wire a_stat  = (paddr == `QDAC_APB_STAT);
	wire a_code  = (paddr[11:4] == 8'(`QDAC_APB_CODE0 >> 4)) &&
	               (paddr[1:0] == 2'b00);
	wire hit     = a_ctrl || a_stat || a_code;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pup_3v_reg <= 1'b0;
		else if (acc && pwrite && a_ctrl)
			pup_3v_reg <= pwdata[0];
	end

	// status: bit 13 idle, 12 bias off, 11:8 settling, 7:4 down, 3 ack
	wire [31:0] stat_word = {18'h0_0000, state_reg == qdac_pkg::QDAC_IDLE,
	                         bias_off, dac_settling, pd_reg, ack_reg,
	                         3'b000};

	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	always_comb begin
		prdata = 32'h0000_0000;
		if (a_ctrl)
			prdata = {31'h0000_0000, pup_3v_reg};
		else if (a_stat)
			prdata = stat_word;
		else if (a_code)
			prdata = {16'h0000, active_reg[paddr[3:2]]};
	end

endmodule
`default_nettype wire

// file: pkg/qdac_defs.svh
/*
 * constants for the quad dac i2c command receiver: addresses, command and
 * channel codes, power-up timing. assumes a 25 mhz pclk.
 */
`ifndef QDAC_DEFS_SVH
`define QDAC_DEFS_SVH

`define QDAC_GLOBAL_ADDR     7'h73
`define QDAC_CMD_WRITE       4'h0
`define QDAC_CMD_UPDATE      4'h1
`define QDAC_CMD_WRITE_UPALL 4'h2
`define QDAC_CMD_WRITE_UP    4'h3
`define QDAC_CMD_POWERDOWN   4'h4
`define QDAC_CMD_NOP         4'hf
`define QDAC_CH_ALL          4'hf
`define QDAC_CODE_MID        16'h8000
`define QDAC_CODE_ZERO       16'h0000
`define QDAC_CLK_MHZ         25
`define QDAC_PUP_SHORT_US    5
`define QDAC_PUP_5V_US       12
`define QDAC_PUP_3V_US       30
`define QDAC_PUP_SHORT_CYC   (`QDAC_PUP_SHORT_US * `QDAC_CLK_MHZ)
`define QDAC_PUP_5V_CYC      (`QDAC_PUP_5V_US * `QDAC_CLK_MHZ)
`define QDAC_PUP_3V_CYC      (`QDAC_PUP_3V_US * `QDAC_CLK_MHZ)
`define QDAC_APB_CTRL        12'h000
`define QDAC_APB_STAT        12'h004
`define QDAC_APB_CODE0       12'h010

`endif

// file: pkg/qdac_pkg.sv
/*
 * types for the quad dac i2c command receiver.
 * assumes nothing beyond qdac_defs.svh.
 */
package qdac_pkg;
	typedef enum logic [4:0] {
		QDAC_IDLE = 5'b00001,
		QDAC_ADDR = 5'b00010,
		QDAC_DATA = 5'b00100,
		QDAC_ACK  = 5'b01000,
		QDAC_SKIP = 5'b10000
	} qdac_state_t;

	typedef struct packed {
		logic [3:0] command_field;
		logic [3:0] channel_select_field;
		logic [15:0] data_word;
	} qdac_word_t;
endpackage

// file: test/qdac_rx_chk.sv
/*
 * port checker for qdac_rx.
 * assumes a bind to qdac_rx and an scl period of at least 8 pclk.
 */
`timescale 1ns/100ps
`default_nettype none
module qdac_rx_chk (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// i2c
	input wire logic        scl_in,
	input wire logic        sda_oe_n,
	// dac side
	input wire logic [63:0] dac_code,
	input wire logic [3:0]  dac_powered_down,
	input wire logic [3:0]  dac_settling,
	input wire logic        bias_off
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [9:0] settle_cnt_reg;
	// longest wake is 750 cycles; one spare for the counter's own edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle_cnt_reg <= '0;
		else
			settle_cnt_reg <= |dac_settling ? settle_cnt_reg + 10'd1 : '0;
	end
	////////////////////////////////////////////////////////////////////////
	sequence ack_begin_s;
		$fell(sda_oe_n) ##0 !scl_in;
	endsequence
	sequence ack_hold_s;
		!sda_oe_n [*6];
	endsequence
	ack_on_low_a: assert property ($fell(sda_oe_n) |-> ack_begin_s)
		else $error("ack started while scl high");
	ack_hold_a: assert property ($fell(sda_oe_n) |-> ack_hold_s)
		else $error("ack released too early");
	pd_keep_a: assert property (
		|(dac_powered_down & ~$past(dac_powered_down)) |-> $stable(dac_code))
		else $error("power-down changed a code");
	code_pd_a: assert property (
		$changed(dac_code[15:0]) |-> !dac_powered_down[0])
		else $error("updated channel still powered down");
	wake_settle_a: assert property (
		|($past(dac_powered_down) & ~dac_powered_down) |-> ##[0:2] |dac_settling)
		else $error("wake without settling");
	bias_a: assert property ($rose(&dac_powered_down) |-> ##[0:1] bias_off)
		else $error("bias not off with all channels down");
	settle_bound_a: assert property (settle_cnt_reg <= 10'd751)
		else $error("settling too long");
	ready_a: assert property (psel && penable |-> pready)
		else $error("apb wait state");
	unmapped_a: assert property (psel && penable && paddr == 12'h008 |-> pslverr)
		else $error("unmapped access without error");
endmodule
`default_nettype wire

// file: test/qdac_i2c_master.sv
/*
 * i2c bus master model: start, stop, byte write with ack sample.
 * assumes pull-ups on both lines; scl period 320 ns, idle high.
 */
`timescale 1ns/100ps
`default_nettype none
module qdac_i2c_master (
	// bus lines, high means released
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic start();
		sda_drv = 1'b1;
		#80 scl = 1'b1;
		#80 sda_drv = 1'b0;
		#80 scl = 1'b0;
		#80;
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		#80 scl = 1'b1;
		#80 sda_drv = 1'b1;
		#160;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			#80 scl = 1'b1;
			#160 scl = 1'b0;
			#80;
		end
		sda_drv = 1'b1;
		#80 scl = 1'b1;
		#80 ack = !sda;
		#80 scl = 1'b0;
		#80;
	endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
/*
 * testbench for qdac_rx: apb access and i2c command scenarios.
 * assumes qdac_i2c_master on the bus and the zero reset code.
 */
`timescale 1ns/100ps
`default_nettype none
`include "qdac_defs.svh"
module tb_top;
	localparam logic [6:0] SELF = 7'h22;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err, scl, sda_drv, sda_out, sda_oe_n;
	logic        bias_off;
	logic [63:0] dac_code;
	logic [3:0]  dac_powered_down, dac_settling;
	wire logic   sda = sda_drv & (sda_oe_n | sda_out);
	int          fails = 0, checked = 0;
	always #20 pclk = ~pclk;
	qdac_rx qdac_rx_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda),
		.sda_out, .sda_oe_n, .slave_addr(SELF), .dac_code, .dac_powered_down,
		.dac_settling, .bias_off);
	qdac_i2c_master qdac_i2c_master_inst (.scl, .sda_drv, .sda);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [63:0] g, e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ab is address and direction; n data bytes, a fourth one is 8'h00
	task automatic xfer(input logic [7:0] ab, input qdac_pkg::qdac_word_t wd,
		input int n, input logic [4:0] exp);
		logic [39:0] bytes;
		logic [4:0]  acks;
		logic        a;
		bytes = {ab, wd, 8'h00};
		acks = '0;
		#7;
		qdac_i2c_master_inst.start();
		for (int i = 0; i <= n; i++) begin
			qdac_i2c_master_inst.wbyte(bytes[39-8*i -: 8], a);
			acks[4-i] = a;
		end
		qdac_i2c_master_inst.stop();
		chk("ack", acks, exp);
	endtask
	task automatic settle_at(input int c, input logic [3:0] e);
		repeat (c) @(negedge pclk);
		chk("settling", dac_settling, e);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h000, 32'h0000_0001);
		apb(1'b0, 12'h000, '0);
		chk("ctrl", rd, 32'h0000_0001);
		apb(1'b0, 12'h008, '0);
		chk("unmapped", {err, rd}, 33'h1_0000_0000);
		xfer({SELF ^ 7'h01, 1'b0}, '{4'h0, 4'h0, 16'h1234}, 3, 5'h00);
		xfer({SELF, 1'b1}, '{4'h0, 4'h0, 16'h0}, 0, 5'h00);
		xfer({SELF, 1'b0}, '{4'h0, 4'h0, 16'h1234}, 3, 5'h1e);
		chk("code", dac_code, '0);
		xfer({SELF, 1'b0}, '{4'h1, 4'h0, 16'hffff}, 3, 5'h1e);
		chk("code", dac_code, 64'h1234);
		xfer({SELF, 1'b0}, '{4'h3, 4'h1, 16'habcd}, 4, 5'h1e);
		chk("code", dac_code, 64'habcd_1234);
		xfer({`QDAC_GLOBAL_ADDR, 1'b0}, '{4'h0, 4'h2, 16'h5555}, 3, 5'h1e);
		xfer({SELF, 1'b0}, '{4'h3, 4'h2, 16'h7777}, 2, 5'h1c);
		chk("code", dac_code, 64'habcd_1234);
		xfer({SELF, 1'b0}, '{4'h2, 4'h3, 16'h0f0f}, 3, 5'h1e);
		chk("code", dac_code, 64'h0f0f_5555_abcd_1234);
		xfer({SELF, 1'b0}, '{4'h4, 4'hf, 16'h0}, 3, 5'h1e);
		chk("down", {bias_off, dac_powered_down}, 5'h1f);
		xfer({SELF, 1'b0}, '{4'hf, 4'h0, 16'h9999}, 3, 5'h1e);
		chk("code", dac_code, 64'h0f0f_5555_abcd_1234);
		xfer({SELF, 1'b0}, '{4'h1, 4'h0, 16'h0}, 3, 5'h1e);
		chk("down", {bias_off, dac_powered_down}, 5'h0e);
		settle_at(600, 4'h1);
		settle_at(200, 4'h0);
		xfer({SELF, 1'b0}, '{4'h1, 4'h1, 16'h0}, 3, 5'h1e);
		settle_at(60, 4'h2);
		settle_at(70, 4'h0);
		chk("code", dac_code, 64'h0f0f_5555_abcd_1234);
		apb(1'b0, 12'h010, '0);
		chk("code a", rd, 32'h0000_1234);
		apb(1'b0, 12'h01c, '0);
		chk("code d", rd, 32'h0000_0f0f);
		apb(1'b0, 12'h004, '0);
		chk("status", rd, 32'h0000_20c0);
		apb(1'b1, 12'h000, 32'h0000_0000);
		xfer({SELF, 1'b0}, '{4'h4, 4'hf, 16'h0}, 3, 5'h1e);
		xfer({SELF, 1'b0}, '{4'h1, 4'h2, 16'h0}, 3, 5'h1e);
		settle_at(260, 4'h4);
		settle_at(60, 4'h0);
		conclude();
	end
	// whole run needs about 213 us
	initial begin
		#1ms;
		fails++;
		conclude();
	end
endmodule
bind qdac_rx qdac_rx_chk qdac_rx_chk_inst (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .scl_in, .sda_oe_n, .dac_code,
	.dac_powered_down, .dac_settling, .bias_off);
`default_nettype wire
